// *** logic/evst_pkg.sv ***
// Package of constants and carrier types for the event and error status block
package evst_pkg;

  // ----------------------------------------------------------------
  // Event status bit positions
  // ----------------------------------------------------------------
  localparam int unsigned BIT_OPDONE = 0;   // Operation complete
  localparam int unsigned BIT_QRYERR = 2;   // Query error
  localparam int unsigned BIT_DDE    = 3;   // Device-dependent error
  localparam int unsigned BIT_EXE    = 4;   // Execution error
  localparam int unsigned BIT_CMDERR = 5;   // Command error
  localparam int unsigned BIT_URQ    = 6;   // User request
  localparam int unsigned BIT_PON    = 7;   // Power-on

  // ----------------------------------------------------------------
  // Widths, depths and reset values
  // ----------------------------------------------------------------
  localparam int unsigned REG_W      = 16;
  localparam int unsigned OQ_DEPTH   = 64;   // Output queue characters
  localparam int unsigned EQ_DEPTH   = 16;   // Error queue slots
  localparam int unsigned EQ_KEEP    = 15;   // Real errors kept
  localparam int unsigned CODE_W     = 8;
  localparam logic [15:0] EVT_RST    = 16'h0000;
  localparam logic [15:0] LIVE_MASK  = 16'h00FD; // Bits 15:8 and 1 read zero
  localparam logic [15:0] ISC_RST    = 16'h0000;
  localparam logic [7:0]  CODE_NONE  = 8'h00;    // Empty error queue answer
  localparam logic [7:0]  CODE_IQA   = 8'h54;    // Query after indefinite response (84)
  localparam logic [7:0]  CODE_OVF   = 8'hFF;    // Overflow code, arbitrary value

  // ----------------------------------------------------------------
  // Status register selector for reads
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    EVST_SEL_EVT,
    EVST_SEL_MASK,
    EVST_SEL_ISC,
    EVST_SEL_ERR
  } evst_sel_t;

  // Error report from the command parser
  typedef struct packed {
    logic              valid;
    logic [1:0]        kind;   // 0 cmd, 1 exe, 2 dde, 3 query
    logic [CODE_W-1:0] code;
  } evst_err_t;

endpackage

// *** logic/evst_status.sv ***
// Event status, enable mask, output queue, error queue and change register
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Summary of operation
// - Query after indefinite response logs error 84
// - Operation complete set when prior commands done
// - Enabled event bits drive event summary flag
// - Event bits stick until read or clear
// - Enable mask restored from saved value
// - Event read clears; mask read does not
// - Reads return bits 0 through 15
// - Command error is event bit 5
// - Summary flag is bit 5; maskable
// - Mask writable only through remote command
// - Queries load output queue; message flag
// - Empty output queue sends nothing
// - Output queue holds 64 characters
// - All error kinds push their code
// - Error query pops oldest; empty gives 0
// - Error flag set while queue nonempty
// - Error queue cleared at power-on and clear status
// - Keep 15 errors, 16th is overflow
// - Change register latches any status toggle
// - Change register cleared at power-on, read
// - Upper byte reads zero except from change register; bit 1 reads zero only from event status and mask
// - Parser query error flushes output queue, logs code
// ----------------------------------------------------------------
module evst_status (
  // Clock and reset
  input  wire logic                       clock,
  input  wire logic                       srst,
  // Power-on and clear events
  input  wire logic                       power_on,
  input  wire logic                       dev_clear,
  input  wire logic                       clear_status,
  // Enable mask write, remote path only
  input  wire logic                       mask_wr,
  input  wire logic [15:0]                mask_wdata,
  input  wire logic [15:0]                mask_saved,
  // Register reads
  input  wire logic                       rd_req,
  input  wire evst_pkg::evst_sel_t        rd_sel,
  output logic [15:0]                     rd_data,
  output logic                            rd_valid,
  // Event sources
  input  wire logic                       op_done_cmd,
  input  wire logic                       exec_idle,
  input  wire logic                       user_req,
  input  wire evst_pkg::evst_err_t        err_in,
  input  wire logic                       indef_pending,
  input  wire logic                       query_rx,
  // Output queue write and controller read
  input  wire logic                       oq_wr,
  input  wire logic [7:0]                 oq_wdata,
  input  wire logic                       oq_rd,
  output logic [7:0]                      oq_rdata,
  output logic                            oq_rvalid,
  output logic                            oq_full,
  // Instrument status input
  input  wire logic [15:0]                instrument_state_reg,
  // Status byte flags
  output logic                            event_summary_flag,
  output logic                            message_available_flag,
  output logic                            error_available_flag,
  output logic [15:0]                     event_enable_mask
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] evt;           // Event status register
    logic [15:0] emask;         // Event enable mask
    logic [15:0] isc;           // Instrument change register
    logic [15:0] state_prev;    // Last sampled instrument state
    logic        done_wait;     // Operation complete pending
    logic [6:0]  oq_cnt;        // Output queue occupancy
    logic [5:0]  oq_wp;
    logic [5:0]  oq_rp;
    logic [4:0]  eq_cnt;        // Error queue occupancy
    logic [3:0]  eq_wp;
    logic [3:0]  eq_rp;
    logic [15:0] rd_data;
    logic        rd_valid;
    logic [7:0]  oq_rdata;
    logic        oq_rvalid;
    // Status byte flags, registered so every output comes from a flop
    logic        summ;          // Event summary
    logic        msg_av;        // Output queue holds data
    logic        err_av;        // Error queue holds codes
    logic        oq_full;
  } evst_state_t;

  evst_state_t s_q;             // Registered state
  evst_state_t s_d;             // Next state

  logic [7:0] oq_mem [evst_pkg::OQ_DEPTH];      // Response characters
  logic [7:0] eq_mem [evst_pkg::EQ_DEPTH];      // Error codes

  logic       eq_push;          // Error code enters queue
  logic [7:0] eq_push_code;
  logic       eq_pop;           // Error query takes oldest
  logic       oq_flush;         // Parser query error or device clear empties output
  logic       oq_push;
  logic       oq_pop;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    s_d          = s_q;
    eq_push      = 1'b0;
    eq_push_code = evst_pkg::CODE_NONE;
    s_d.rd_valid = 1'b0;
    s_d.oq_rvalid = 1'b0;

    // Queue operations decided first
    oq_flush = dev_clear | (err_in.valid & (err_in.kind == 2'd3));
    oq_pop   = oq_rd & (s_q.oq_cnt != 7'd0) & ~oq_flush;
    oq_push  = oq_wr & ~s_q.oq_full & ~oq_flush;
    eq_pop   = rd_req & (rd_sel == evst_pkg::EVST_SEL_ERR)
             & (s_q.eq_cnt != 5'd0);

    // Reads: event and change register reads clear, error read pops, mask read leaves state alone
    if (rd_req) begin
      s_d.rd_valid = 1'b1;
      case (rd_sel)
        evst_pkg::EVST_SEL_EVT: begin
          // A bit set in this same cycle survives for the next read
          s_d.rd_data = s_q.evt & evst_pkg::LIVE_MASK;
          s_d.evt     = evst_pkg::EVT_RST;
        end
        evst_pkg::EVST_SEL_MASK: begin
          s_d.rd_data = s_q.emask;
        end
        evst_pkg::EVST_SEL_ISC: begin
          s_d.rd_data = s_q.isc;
          s_d.isc     = evst_pkg::ISC_RST;
        end
        evst_pkg::EVST_SEL_ERR: begin
          // Oldest code, or zero when nothing is queued
          s_d.rd_data = (s_q.eq_cnt != 5'd0) ? {8'h00, eq_mem[s_q.eq_rp]}
                                              : {8'h00, evst_pkg::CODE_NONE};
        end
        default: begin
          s_d.rd_data = 16'h0000;
        end
      endcase
    end

    // Change register: toggles since last read; set wins over read clear
    // The first sample after reset compares against zero, so a state bit
    // that comes up high shows once as a change
    s_d.isc        = s_d.isc | (instrument_state_reg ^ s_q.state_prev);
    s_d.state_prev = instrument_state_reg;

    // Operation complete waits for the engine to drain
    if (op_done_cmd) begin
      s_d.done_wait = 1'b1;
    end
    if ((op_done_cmd | s_q.done_wait) & exec_idle) begin
      s_d.evt[evst_pkg::BIT_OPDONE] = 1'b1;
      s_d.done_wait = 1'b0;
    end

    // Error events: flag bit and queued code
    if (err_in.valid) begin
      eq_push      = 1'b1;
      eq_push_code = err_in.code;
      case (err_in.kind)
        2'd0:    s_d.evt[evst_pkg::BIT_CMDERR] = 1'b1;
        2'd1:    s_d.evt[evst_pkg::BIT_EXE] = 1'b1;
        2'd2:    s_d.evt[evst_pkg::BIT_DDE] = 1'b1;
        default: s_d.evt[evst_pkg::BIT_QRYERR] = 1'b1;
      endcase
    end else if (query_rx & indef_pending) begin
      // New query before the indefinite response was read
      eq_push      = 1'b1;
      eq_push_code = evst_pkg::CODE_IQA;
      s_d.evt[evst_pkg::BIT_QRYERR] = 1'b1;
    end
    // A parser error and a late query in one cycle log only the parser's
    // code; the queue takes one push per cycle to keep the write port single
    if (user_req) begin
      s_d.evt[evst_pkg::BIT_URQ] = 1'b1;
    end

    // Clears; stored bits otherwise stick
    if (clear_status | dev_clear) begin
      s_d.evt       = evst_pkg::EVT_RST;
      s_d.done_wait = 1'b0;
    end
    if (clear_status) begin
      s_d.eq_cnt = 5'd0;
      s_d.eq_wp  = 4'd0;
      s_d.eq_rp  = 4'd0;
    end

    // Mask writes come only from the remote path port
    if (mask_wr) begin
      s_d.emask = mask_wdata & evst_pkg::LIVE_MASK;
    end

    // Power-on: restore mask, clear error queue and change register, flag power-on
    if (power_on) begin
      s_d.emask     = mask_saved & evst_pkg::LIVE_MASK;
      s_d.evt       = evst_pkg::EVT_RST;
      s_d.evt[evst_pkg::BIT_PON] = 1'b1;
      s_d.isc       = evst_pkg::ISC_RST;
      s_d.eq_cnt    = 5'd0;
      s_d.eq_wp     = 4'd0;
      s_d.eq_rp     = 4'd0;
      s_d.done_wait = 1'b0;
      eq_push       = 1'b0;
    end
    // Dead bits are forced low after every writer, so no path can leave
    // a one in the upper byte or in bit 1
    s_d.evt = s_d.evt & evst_pkg::LIVE_MASK;

    // Error queue: counted FIFO with overflow slot
    if (!(power_on | clear_status)) begin
      if (eq_pop) begin
        s_d.eq_rp  = s_q.eq_rp + 4'd1;
        s_d.eq_cnt = s_d.eq_cnt - 5'd1;
      end
      if (eq_push && (s_q.eq_cnt < 5'(evst_pkg::EQ_DEPTH) || eq_pop)) begin
        s_d.eq_wp  = s_q.eq_wp + 4'd1;
        s_d.eq_cnt = s_d.eq_cnt + 5'd1;
      end
    end

    // Output queue pointers
    if (oq_flush) begin
      s_d.oq_cnt = 7'd0;
      s_d.oq_wp  = 6'd0;
      s_d.oq_rp  = 6'd0;
    end else begin
      if (oq_pop) begin
        s_d.oq_rdata  = oq_mem[s_q.oq_rp];
        s_d.oq_rvalid = 1'b1;
        s_d.oq_rp     = s_q.oq_rp + 6'd1;
      end
      if (oq_push) begin
        s_d.oq_wp = s_q.oq_wp + 6'd1;
      end
      s_d.oq_cnt = s_q.oq_cnt + {6'd0, oq_push} - {6'd0, oq_pop};
    end

    // Status byte flags from next values, no stale cycle
    // The summary is an OR over all sixteen bits; dead bits are already
    // zero on both sides, so the mask needs no extra gating
    s_d.summ    = |(s_d.evt & s_d.emask);
    s_d.msg_av  = (s_d.oq_cnt != 7'd0);
    s_d.err_av  = (s_d.eq_cnt != 5'd0);
    s_d.oq_full = (s_d.oq_cnt == 7'(evst_pkg::OQ_DEPTH));
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Queue storage; arrays carry no reset to stay RAM-like
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (oq_push) begin
      oq_mem[s_q.oq_wp] <= oq_wdata;
    end
    // Once the overflow entry lands, pushes are dropped until a pop frees a slot
    // Pointers wrap on their own width; the count alone tells full from empty
    // Slot 16 only ever takes the overflow code
    if (!(power_on | clear_status | srst) && eq_push
        && (s_q.eq_cnt < 5'(evst_pkg::EQ_DEPTH) || eq_pop)) begin
      if (s_q.eq_cnt - {4'd0, eq_pop} >= 5'(evst_pkg::EQ_KEEP)) begin
        eq_mem[s_q.eq_wp] <= evst_pkg::CODE_OVF;
      end else begin
        eq_mem[s_q.eq_wp] <= eq_push_code;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs straight from flops
  // ----------------------------------------------------------------
  assign rd_data                = s_q.rd_data;
  assign rd_valid               = s_q.rd_valid;
  assign oq_rdata               = s_q.oq_rdata;
  assign oq_rvalid              = s_q.oq_rvalid;
  assign oq_full                = s_q.oq_full;
  assign event_summary_flag     = s_q.summ;
  assign message_available_flag = s_q.msg_av;
  assign error_available_flag   = s_q.err_av;
  // The mask leaves the block so the host can save it before power-down
  assign event_enable_mask      = s_q.emask;

endmodule

// *** sim/evst_ctrl_model.sv ***
// Bus controller model that reads response characters from the block
`timescale 1ns/1ps
module evst_ctrl_model (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       srst,
  // Pace set by the bench; gap of 0 reads every cycle
  input  wire logic       drain,
  input  wire logic [1:0] gap,
  // Read strobe toward the block
  output logic            oq_rd
);
  logic [1:0] wait_q;  // Idle cycles left before the next read

  // Keeps reading past empty on purpose, as a careless controller would
  always @(negedge clock) begin
    if (srst || !drain) begin
      oq_rd  <= 1'b0;
      wait_q <= 2'd0;
    end else if (wait_q != 2'd0) begin
      oq_rd  <= 1'b0;
      wait_q <= wait_q - 2'd1;
    end else begin
      oq_rd  <= 1'b1;
      wait_q <= gap;
    end
  end
endmodule

// *** sim/evst_status_chk.sv ***
// Port-level checks for the event and error status block
`timescale 1ns/1ps
module evst_status_chk (
  // Clock and reset
  input wire logic                clock,
  input wire logic                srst,
  // Requests into the block
  input wire logic                power_on,
  input wire logic                dev_clear,
  input wire logic                clear_status,
  input wire logic                mask_wr,
  input wire logic [15:0]         mask_wdata,
  input wire logic                rd_req,
  input wire evst_pkg::evst_sel_t rd_sel,
  input wire evst_pkg::evst_err_t err_in,
  input wire logic                oq_wr,
  input wire logic                oq_rd,
  // Answers and flags
  input wire logic [15:0]         rd_data,
  input wire logic                rd_valid,
  input wire logic                oq_rvalid,
  input wire logic                event_summary_flag,
  input wire logic                message_available_flag,
  input wire logic                error_available_flag,
  input wire logic [15:0]         event_enable_mask
);
  // ----------------------------------------------------------------
  // Assertions, all in the one clock domain
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  a_evt_answer: assert property (
    rd_req && rd_sel == evst_pkg::EVST_SEL_EVT
      |=> rd_valid && rd_data[15:8] == 8'h00 && !rd_data[1])
    else $error("event status answer late or has dead bits set");
  a_mask_write: assert property (
    mask_wr && !power_on |=> event_enable_mask == ($past(mask_wdata) & evst_pkg::LIVE_MASK))
    else $error("enable mask not loaded from remote write");
  a_summary_quiet: assert property (
    event_enable_mask == 16'h0000 |-> !event_summary_flag)
    else $error("summary flag set with every event masked");
  a_cme_summary: assert property (
    err_in.valid && err_in.kind == 2'd0 && event_enable_mask[5] && !mask_wr && !power_on
      && !clear_status && !dev_clear |=> event_summary_flag)
    else $error("command error did not raise summary flag");
  a_err_avail: assert property (
    err_in.valid && !clear_status && !power_on |=> error_available_flag)
    else $error("error push did not raise error flag");
  a_clear_queue: assert property (
    clear_status |=> !error_available_flag)
    else $error("clear status left errors queued");
  a_empty_silent: assert property (
    oq_rd && !message_available_flag |=> !oq_rvalid)
    else $error("empty output queue answered a read");
  a_mav_load: assert property (
    oq_wr && !dev_clear && !(err_in.valid && err_in.kind == 2'd3) |=> message_available_flag)
    else $error("loaded output queue shows no message");
endmodule

// *** sim/testbench.sv ***
// Self-checking bench for the event and error status block
`timescale 1ns/1ps
module testbench;
  // ----------------------------------------------------------------
  // Signals and bookkeeping
  // ----------------------------------------------------------------
  logic                clock = 1'b0;
  logic                srst, power_on, dev_clear, clear_status, mask_wr, rd_req;
  logic                op_done_cmd, exec_idle, user_req, indef_pending, query_rx, oq_wr;
  logic                drain, rd_valid, oq_rd, oq_rvalid, oq_full, esf, msg_flag, err_flag;
  logic [15:0]         mask_wdata, mask_saved, rd_data, inst_state, eem, v16;
  logic [7:0]          oq_wdata, oq_rdata, code;
  logic [1:0]          gap;
  evst_pkg::evst_sel_t rd_sel;
  evst_pkg::evst_err_t err_in;
  logic [15:0]         word_q[$];   // Expected register answers
  logic [7:0]          chr_q[$];    // Expected response characters
  logic [7:0]          codes[$];    // Error codes pushed in order
  int                  seed = 34099;
  int                  miscompares = 0;
  int                  checks_done = 0;

  always #5 clock = ~clock;

  evst_status u_evst_status (.clock, .srst, .power_on, .dev_clear, .clear_status, .mask_wr,
    .mask_wdata, .mask_saved, .rd_req, .rd_sel, .rd_data, .rd_valid, .op_done_cmd, .exec_idle,
    .user_req, .err_in, .indef_pending, .query_rx, .oq_wr, .oq_wdata, .oq_rd, .oq_rdata,
    .oq_rvalid, .oq_full, .instrument_state_reg(inst_state), .event_summary_flag(esf),
    .message_available_flag(msg_flag), .error_available_flag(err_flag),
    .event_enable_mask(eem));
  evst_ctrl_model u_evst_ctrl_model (.clock, .srst, .drain, .gap, .oq_rd);

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic cmp_word(input string what, input logic [15:0] exp, got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmp_flag(input string what, input logic exp, got);
    cmp_word(what, {15'h0000, exp}, {15'h0000, got});
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic pulse(ref logic sig);
    @(negedge clock);
    sig = 1'b1;
    @(negedge clock);
    sig = 1'b0;
  endtask
  // Selector: 0 event status, 1 mask, 2 change register, 3 error queue
  task automatic rd(input logic [1:0] sel, input logic [15:0] exp);
    @(negedge clock);
    rd_sel = evst_pkg::evst_sel_t'(sel);
    rd_req = 1'b1;
    word_q.push_back(exp);
    @(negedge clock);
    rd_req = 1'b0;
  endtask
  task automatic err(input logic [1:0] kind, input logic [7:0] c);
    @(negedge clock);
    err_in = '{1'b1, kind, c};
    @(negedge clock);
    err_in = '0;
  endtask
  // Streams random characters; keep=0 for ones that must be dropped or flushed
  task automatic load(input int n, input bit keep);
    repeat (n) begin
      @(negedge clock);
      oq_wr = 1'b1;
      oq_wdata = 8'($random(seed));
      if (keep) chr_q.push_back(oq_wdata);
    end
    @(negedge clock);
    oq_wr = 1'b0;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Watcher: pairs each answer with the oldest note
  always @(negedge clock) begin
    if (rd_valid === 1'b1) cmp_word("rd_data", word_q.pop_front(), rd_data);
    if (oq_rvalid === 1'b1) begin
      if (chr_q.size() == 0) cmp_flag("oq_rvalid", 1'b0, oq_rvalid);
      else cmp_word("oq_rdata", {8'h00, chr_q.pop_front()}, {8'h00, oq_rdata});
    end
  end

  // Hang guard, far beyond the roughly 530 cycles of the sequence
  initial begin
    #100000;
    miscompares++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {power_on, dev_clear, clear_status, mask_wr, rd_req, op_done_cmd, exec_idle} = '0;
    {user_req, indef_pending, query_rx, oq_wr, drain, mask_wdata, inst_state, oq_wdata, gap} = '0;
    err_in = '0;
    rd_sel = evst_pkg::EVST_SEL_EVT;
    mask_saved = 16'h0021;
    srst = 1'b1;
    tick(10);
    srst = 1'b0;
    pulse(power_on);
    rd(2'd1, 16'h0021);
    cmp_word("eem", 16'h0021, eem);
    rd(2'd0, 16'h0080);
    rd(2'd0, 16'h0000);
    err(2'd0, 8'h65);
    cmp_flag("esf", 1'b1, esf);
    cmp_flag("err_flag", 1'b1, err_flag);
    mask_wdata = 16'hFFDF;
    pulse(mask_wr);
    cmp_flag("esf", 1'b0, esf);
    rd(2'd1, 16'h00DD);
    rd(2'd0, 16'h0020);
    // Every error kind, the query one flushing pending output
    load(3, 1'b0);
    cmp_flag("msg_flag", 1'b1, msg_flag);
    for (int k = 0; k < 4; k++) err(2'(k), 8'(k + 16));
    cmp_flag("msg_flag", 1'b0, msg_flag);
    rd(2'd0, 16'h003C);
    rd(2'd3, 16'h0065);
    for (int k = 0; k < 4; k++) rd(2'd3, 16'(k + 16));
    rd(2'd3, 16'h0000);
    cmp_flag("err_flag", 1'b0, err_flag);
    // Overflow: twenty errors, fifteen kept
    repeat (20) begin
      code = 8'({$random(seed)} % 254 + 1);
      codes.push_back(code);
      err(2'd1, code);
    end
    for (int i = 0; i < 15; i++) rd(2'd3, {8'h00, codes[i]});
    rd(2'd3, {8'h00, evst_pkg::CODE_OVF});
    rd(2'd3, {8'h00, evst_pkg::CODE_NONE});
    err(2'd2, 8'h5A);
    pulse(clear_status);
    cmp_flag("err_flag", 1'b0, err_flag);
    rd(2'd0, 16'h0000);
    // Query during an unread indefinite response
    indef_pending = 1'b1;
    pulse(query_rx);
    indef_pending = 1'b0;
    rd(2'd0, 16'h0004);
    rd(2'd3, {8'h00, evst_pkg::CODE_IQA});
    pulse(user_req);
    pulse(dev_clear);
    rd(2'd0, 16'h0000);
    // Operation complete waits for idle execution
    pulse(op_done_cmd);
    tick(3);
    rd(2'd0, 16'h0000);
    exec_idle = 1'b1;
    tick(2);
    cmp_flag("esf", 1'b1, esf);
    rd(2'd0, 16'h0001);
    // Change register sees rise and fall
    v16 = 16'($random(seed));
    inst_state = v16;
    tick(2);
    inst_state = 16'h0000;
    tick(2);
    rd(2'd2, v16);
    rd(2'd2, 16'h0000);
    // Fill past 64, then drain at a random pace
    load(64, 1'b1);
    load(1, 1'b0);
    cmp_flag("oq_full", 1'b1, oq_full);
    gap = 2'($random(seed));
    drain = 1'b1;
    tick(300);
    drain = 1'b0;
    cmp_word("oq_left", 16'h0000, 16'(chr_q.size()));
    cmp_flag("msg_flag", 1'b0, msg_flag);
    tally_and_finish();
  end
endmodule

bind evst_status evst_status_chk u_evst_status_chk (.clock, .srst, .power_on, .dev_clear,
  .clear_status, .mask_wr, .mask_wdata, .rd_req, .rd_sel, .err_in, .oq_wr, .oq_rd, .rd_data,
  .rd_valid, .oq_rvalid, .event_summary_flag, .message_available_flag, .error_available_flag,
  .event_enable_mask);
